// ### hdl/ewp_mem.sv
// byte memory for main array and id page, registered read port
module ewp_mem #(
  parameter int DEPTH = 1040,
  parameter int AW = 11
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // ewp_mem

// ### hdl/ewp_pkg.sv
// constants shared by the two-wire eeprom write target
package ewp_pkg;
  localparam int CLK_MHZ = 125;
  localparam int WRITE_TIME_US = 4;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int ADDR_W = 10;
  localparam int PAGE_BYTES = 16;
  localparam int ID_BYTES = 16;
  localparam int LOCK_DATA_BIT = 1;
  localparam int ID_SEL_BIT = 7;
  localparam logic [7:0] ID_CODE0 = 8'h5A;
  localparam logic [7:0] ID_CODE1 = 8'h3C;
  localparam logic [7:0] ID_CODE2 = 8'h11;
endpackage

// ### hdl/ewp_target.sv
// two-wire target write logic with page buffer and id page lock
// Functional notes
// - non-matching select byte: release bus, go idle until next start
// - matching select byte acknowledged in the ninth clock period
// - one address byte follows the select byte and is acknowledged
// - main array address: select bits b2,b1 high, address byte low
// - id page write: type 1011b, address bit7 zero, bits 3..0 byte
// - lock: type 1011b, address bit7 one, data bit1 set
// - lock is sticky, only reset clears it
// - locked id page: data bytes not acknowledged, page unchanged
// - sixteen byte id page, first three bytes hold an id code
// - write cycle starts only on stop right after a data ack
// - during write cycle data output off and bus ignored
// - after main array write cycle counter points past last written byte; id page writes leave it unchanged
// - write protect high: ack select/address, nack data, no write
// - byte write is one data byte then stop
// - page write wraps within the page, overwriting earlier bytes
// - byte counter advances after each acknowledged data byte
// - polling select bytes nacked while busy, acked when done
// - select matches only 1010b/1011b with b3 equal chip select strap and b0 low
// - data sampled on rising scl, master changes sda while scl low
module ewp_target #(
  parameter int WRITE_CYCLES = ewp_pkg::WRITE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect_in,
  input wire logic chip_select_strap,
  output logic busy,
  output logic id_locked
);
  localparam int MW = ewp_pkg::ADDR_W + 1;
  typedef enum logic [2:0] {
    EWP_IDLE = 3'b000,
    EWP_SEL = 3'b001,
    EWP_ADDR = 3'b010,
    EWP_DATA = 3'b011,
    EWP_PROG = 3'b100
  } ewp_state_t;

  logic rst_s1_reg, rst_n_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // bus edge detection; pins are already synchronous
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_in && !scl_d_reg;
  assign scl_fall = !scl_in && scl_d_reg;
  assign start_ev = scl_in && scl_d_reg && sda_d_reg && !sda_in;
  assign stop_ev = scl_in && scl_d_reg && !sda_d_reg && sda_in;

  ewp_state_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic ack_reg, ack_next;
  logic idsel_reg, idsel_next;
  logic [1:0] hi_reg, hi_next;
  logic [7:0] addr_reg, addr_next;
  logic [3:0] ptr_reg, ptr_next;
  logic lockcmd_reg, lockcmd_next;
  logic lock_reg, lock_next;
  logic armed_reg, armed_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] buf_reg [ewp_pkg::PAGE_BYTES];
  logic [ewp_pkg::PAGE_BYTES-1:0] bval_reg, bval_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [ewp_pkg::ADDR_W-1:0] ctr_reg, ctr_next;
  logic [3:0] last_reg, last_next;
  logic [4:0] cp_reg, cp_next;
  logic buf_we;
  logic [7:0] buf_wd;
  logic mem_we;
  logic [MW-1:0] mem_wa;

  function automatic logic sel_match(input logic [7:0] b, input logic cs);
    return (b[7:4] == ewp_pkg::TYPE_MAIN || b[7:4] == ewp_pkg::TYPE_ID)
      && b[3] == cs && !b[0];
  endfunction

  function automatic logic [MW-1:0] mem_addr(input logic id, input logic [1:0] hi,
                                             input logic [7:0] a, input logic [3:0] p);
    if (id) begin
      return MW'(2 ** ewp_pkg::ADDR_W) + MW'(p);
    end
    return {1'b0, hi, a[7:4], p};
  endfunction

  logic [7:0] sh_in;
  assign sh_in = {sh_reg[6:0], sda_in};

  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    ack_next = ack_reg;
    idsel_next = idsel_reg;
    hi_next = hi_reg;
    addr_next = addr_reg;
    ptr_next = ptr_reg;
    lockcmd_next = lockcmd_reg;
    lock_next = lock_reg;
    armed_next = armed_reg;
    cnt_next = cnt_reg;
    bval_next = bval_reg;
    tmr_next = tmr_reg;
    ctr_next = ctr_reg;
    last_next = last_reg;
    cp_next = cp_reg;
    buf_we = 1'b0;
    buf_wd = sh_in;
    if (st_reg == EWP_PROG) begin
      if (cp_reg < 5'(ewp_pkg::PAGE_BYTES)) begin
        cp_next = cp_reg + 5'd1;
      end
      if (tmr_reg != 32'd0) begin
        tmr_next = tmr_reg - 32'd1;
      end else if (cp_reg == 5'(ewp_pkg::PAGE_BYTES)) begin
        st_next = EWP_IDLE;
        bval_next = '0;
        ctr_next = idsel_reg ? ctr_reg : {hi_reg, addr_reg[7:4], last_reg + 4'd1};
        if (lockcmd_reg) begin
          lock_next = 1'b1;
        end
      end
    end else if (start_ev) begin
      st_next = EWP_SEL;
      bit_next = 4'd0;
      ack_next = 1'b0;
      armed_next = 1'b0;
      cnt_next = 5'd0;
      bval_next = '0;
      lockcmd_next = 1'b0;
    end else if (stop_ev) begin
      // stop in the slot after a data ack; its rising scl already counted a bit
      if (st_reg == EWP_DATA && armed_reg && bit_reg == 4'd1 && (|bval_reg || lockcmd_reg)) begin
        st_next = EWP_PROG;
        tmr_next = 32'(WRITE_CYCLES);
        cp_next = 5'd0;
      end else begin
        st_next = EWP_IDLE;
      end
      ack_next = 1'b0;
    end else if (st_reg != EWP_IDLE && scl_fall) begin
      if (bit_reg == 4'd8) begin
        // ack waits for the eighth fall so sda never drops while scl is high
        bit_next = 4'd9;
      end else if (bit_reg == 4'd9) begin
        ack_next = 1'b0;
        bit_next = 4'd0;
      end else begin
        // slot after the ack ended without a stop
        armed_next = 1'b0;
      end
    end else if (st_reg != EWP_IDLE && scl_rise) begin
      if (bit_reg == 4'd9) begin
        armed_next = (st_reg == EWP_DATA) && ack_reg;
      end else begin
        sh_next = sh_in;
        bit_next = bit_reg + 4'd1;
        if (bit_reg == 4'd7) begin
          unique case (st_reg)
            EWP_SEL: begin
              if (sel_match(sh_in, chip_select_strap)) begin
                ack_next = 1'b1;
                idsel_next = sh_in[4];
                hi_next = sh_in[2:1];
                st_next = EWP_ADDR;
              end else begin
                st_next = EWP_IDLE;
              end
            end
            EWP_ADDR: begin
              ack_next = 1'b1;
              addr_next = sh_in;
              // bit7 selects lock on id page
              lockcmd_next = 1'b0;
              ptr_next = sh_in[3:0];
              st_next = EWP_DATA;
            end
            EWP_DATA: begin
              // protect or locked page: no ack, no store
              if (!write_protect_in && !(idsel_reg && lock_reg)) begin
                ack_next = 1'b1;
                if (idsel_reg && addr_reg[ewp_pkg::ID_SEL_BIT]) begin
                  // only a single lock byte counts; a second byte cancels it
                  lockcmd_next = (cnt_reg == 5'd0) && sh_in[ewp_pkg::LOCK_DATA_BIT];
                end else begin
                  buf_we = 1'b1;
                  bval_next[ptr_reg] = 1'b1;
                  last_next = ptr_reg;
                end
                ptr_next = ptr_reg + 4'd1;
                if (cnt_reg != 5'd31) begin
                  cnt_next = cnt_reg + 5'd1;
                end
              end
            end
            default: st_next = EWP_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= EWP_IDLE;
      bit_reg <= 4'd0;
      sh_reg <= 8'h00;
      ack_reg <= 1'b0;
      idsel_reg <= 1'b0;
      hi_reg <= 2'b00;
      addr_reg <= 8'h00;
      ptr_reg <= 4'h0;
      lockcmd_reg <= 1'b0;
      lock_reg <= 1'b0;
      armed_reg <= 1'b0;
      cnt_reg <= 5'd0;
      bval_reg <= '0;
      tmr_reg <= 32'd0;
      ctr_reg <= '0;
      last_reg <= 4'h0;
      cp_reg <= 5'd0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      ack_reg <= ack_next;
      idsel_reg <= idsel_next;
      hi_reg <= hi_next;
      addr_reg <= addr_next;
      ptr_reg <= ptr_next;
      lockcmd_reg <= lockcmd_next;
      lock_reg <= lock_next;
      armed_reg <= armed_next;
      cnt_reg <= cnt_next;
      bval_reg <= bval_next;
      tmr_reg <= tmr_next;
      ctr_reg <= ctr_next;
      last_reg <= last_next;
      cp_reg <= cp_next;
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end

  // page buffer holds data until the stop commits it
  always_ff @(posedge clk_sys) begin
    if (buf_we) begin
      buf_reg[ptr_reg] <= buf_wd;
    end
  end

  // commit one buffered byte per cycle during the write cycle
  assign mem_we = (st_reg == EWP_PROG) && (cp_reg < 5'(ewp_pkg::PAGE_BYTES))
    && bval_reg[cp_reg[3:0]];
  assign mem_wa = mem_addr(idsel_reg, hi_reg, addr_reg, cp_reg[3:0]);

  // id page lives above the main array; factory bytes preloaded by loader
  ewp_mem #(
    .DEPTH(2 ** ewp_pkg::ADDR_W + ewp_pkg::ID_BYTES),
    .AW(MW)
  ) u_mem (
    .clk_sys(clk_sys),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(buf_reg[cp_reg[3:0]]),
    .raddr(mem_wa),
    .rdata()
  );

  // open drain low only for ack, never while busy
  assign sda_out = 1'b0;
  assign sda_oe = ack_reg && bit_reg == 4'd9 && st_reg != EWP_PROG;
  assign busy = st_reg == EWP_PROG;
  assign id_locked = lock_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n_reg);

  sequence s_stop_after_ack;
    st_reg == EWP_DATA && armed_reg && bit_reg == 4'd1 && (|bval_reg || lockcmd_reg) ##0 stop_ev;
  endsequence

  chk_stop_starts_write: assert property (s_stop_after_ack |=> busy)
    else $error("write cycle not started after stop");
  chk_stop_other_slot: assert property (stop_ev && !armed_reg && !busy |=> !busy)
    else $error("write cycle started from wrong slot");
  chk_busy_no_drive: assert property (busy |-> !sda_oe)
    else $error("sda driven while busy");
  chk_lock_sticky: assert property (id_locked |=> id_locked)
    else $error("lock cleared");
  chk_protect_no_store: assert property (st_reg == EWP_DATA && write_protect_in
    |-> !buf_we)
    else $error("protected data stored");
  chk_locked_no_ack: assert property (st_reg == EWP_DATA && idsel_reg && id_locked
    && scl_rise && bit_reg == 4'd7 |=> !ack_reg)
    else $error("locked id page data acked");
  chk_sel_ack: assert property (st_reg == EWP_SEL && scl_rise && bit_reg == 4'd7
    && sel_match(sh_in, chip_select_strap) && !start_ev && !stop_ev
    |=> ack_reg && st_reg == EWP_ADDR)
    else $error("select byte not acked");
  chk_sel_reject: assert property (st_reg == EWP_SEL && scl_rise && bit_reg == 4'd7
    && !sel_match(sh_in, chip_select_strap) && !start_ev && !stop_ev
    |=> st_reg == EWP_IDLE && !sda_oe)
    else $error("non matching select not released");
  chk_wrap_page: assert property (buf_we && ptr_reg == 4'hF |=> ptr_reg == 4'h0)
    else $error("page pointer did not wrap");
endmodule // ewp_target

// ### test/ewp_master.sv
// two-wire bus master model for the eeprom write target
module ewp_master (
  input wire logic clk_sys,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // sda moves only while scl low
  task automatic bit_io(input logic b, output logic seen);
    sda_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(3);
    seen = sda;
    scl = 1'b0;
    tick(2);
  endtask
  // start, also usable as repeated start
  task automatic start();
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_low = 1'b0;
    tick(3);
  endtask
  // bytes msb first, ninth bit released for the ack
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
endmodule // ewp_master

// ### test/testbench.sv
// self-checking bench for the eeprom write target
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, arst_n, wp, strap, scl, sda_low, sda_out, sda_oe, busy, id_locked;
  wire logic sda;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // {select, strap, expected ack}
  localparam logic [9:0] SELS [7] = '{10'h281, 10'h2A0, 10'h2A3, 10'h2C1, 10'h300,
    10'h284, 10'h080};
  // open drain wire with pull-up
  assign sda = !(sda_low || (sda_oe && !sda_out));
  ewp_target #(.WRITE_CYCLES(200)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect_in(wp), .chip_select_strap(strap), .busy(busy), .id_locked(id_locked));
  ewp_master m_u (.clk_sys(clk_sys), .scl(scl), .sda_low(sda_low), .sda(sda));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, a full run needs under 15000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_val(input string what, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic poll();
    logic a;
    int n;
    n = 0;
    a = 1'b0;
    while (!a && n < 8) begin
      m_u.start();
      m_u.send(8'hA0, a);
      n++;
    end
    m_u.stop();
    chk("poll nacked first", 1'b1, n > 1);
    chk("poll ack", 1'b1, a);
    chk("busy after poll", 1'b0, busy);
  endtask
  // select, address, data bytes, stop; expected data ack and write start
  task automatic wr(input logic [7:0] sel, adr, dat, input int cnt, input logic dack);
    logic a;
    m_u.start();
    m_u.send(sel, a);
    chk("select ack", 1'b1, a);
    m_u.send(adr, a);
    chk("address ack", 1'b1, a);
    for (int i = 0; i < cnt; i++) begin
      m_u.send(dat + 8'(i), a);
      chk("data ack", dack, a);
    end
    m_u.stop();
    chk("busy after stop", dack, busy);
    if (dack) poll();
  endtask
  task automatic t_select();
    logic a;
    foreach (SELS[i]) begin
      strap = SELS[i][1];
      m_u.start();
      m_u.send(SELS[i][9:2], a);
      chk("select match", SELS[i][0], a);
      m_u.stop();
      chk("no write", 1'b0, busy);
    end
    strap = 1'b0;
    $display("t_select done");
  endtask
  task automatic t_writes();
    logic a;
    wr(8'hA6, 8'h55, 8'h12, 1, 1'b1);
    chk_val("byte write", 10'h012, dut_u.u_mem.mem[11'h355]);
    wr(8'hA2, 8'h0E, 8'h40, 17, 1'b1);
    chk_val("rolled byte", 10'h050, dut_u.u_mem.mem[11'h10E]);
    chk_val("wrapped byte", 10'h042, dut_u.u_mem.mem[11'h100]);
    chk_val("page next address", 10'h10F, dut_u.ctr_reg);
    wp = 1'b1;
    wr(8'hA6, 8'h55, 8'h77, 2, 1'b0);
    chk_val("protected byte", 10'h012, dut_u.u_mem.mem[11'h355]);
    wp = 1'b0;
    m_u.start();
    m_u.send(8'hA0, a);
    m_u.send(8'h20, a);
    m_u.stop();
    chk("stop after address", 1'b0, busy);
    $display("t_writes done");
  endtask
  task automatic t_lock();
    logic a;
    wr(8'hB0, 8'h73, 8'hC5, 3, 1'b1);
    chk_val("id byte", 10'h0C5, dut_u.u_mem.mem[11'h403]);
    // lock byte with bit1 clear is acked but starts no write cycle
    m_u.start();
    m_u.send(8'hB0, a);
    chk("select ack", 1'b1, a);
    m_u.send(8'h80, a);
    chk("address ack", 1'b1, a);
    m_u.send(8'hFD, a);
    chk("lock byte ack", 1'b1, a);
    m_u.stop();
    chk("no lock cycle", 1'b0, busy);
    chk("lock ignored", 1'b0, id_locked);
    wr(8'hB4, 8'hFF, 8'h02, 1, 1'b1);
    chk("locked", 1'b1, id_locked);
    wr(8'hB0, 8'h05, 8'h99, 2, 1'b0);
    chk_val("locked id byte", 10'h0C7, dut_u.u_mem.mem[11'h405]);
    wr(8'hA0, 8'h30, 8'h01, 1, 1'b1);
    chk_val("next address", 10'h031, dut_u.ctr_reg);
    chk("lock stays", 1'b1, id_locked);
    $display("t_lock done");
  endtask
  initial begin
    arst_n = 1'b0;
    wp = 1'b0;
    strap = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    m_u.tick(6);
    t_select();
    t_writes();
    t_lock();
    complete_run();
  end
endmodule // testbench
